// ---- logic/tscn_notify.sv ----
// Purpose: Serial slave with data-ready handshake and state-change notify output.
// Assumes: Host is master, drives select, clock and data-in; 3-byte frames.
// Notes: Floatable outputs go to high-impedance (enable high) in reset, and in sleep while the state is busy.
`timescale 1ns/100ps
// Notes on behaviour
// - Key press, release or scroll movement raises change
// - Change goes high after every reset
// - Change drops after host reads status
// - Device is slave; host makes clock, select
// - Floatable outputs may float in reset, sleep
// - Three bytes exchanged each way per frame
// - Data-ready output gives host flow control
module tscn_notify
  import tscn_pkg::*;
#(
  parameter int unsigned READY_MIN = READY_MIN_CYC,
  parameter int unsigned XFER_TIMEOUT = XFER_TIMEOUT_CYC,
  parameter int unsigned BURST = BURST_CYC
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_link_clk,
  input wire logic i_ss_n,
  input wire logic i_mosi,
  input wire logic i_sleep,
  input wire logic [23:0] i_key_status,
  input wire logic i_state_event,
  output logic o_change,
  output logic o_change_oe_n,
  output logic o_transfer_ready_handshake,
  output logic o_transfer_ready_handshake_oe_n,
  output logic o_miso,
  output logic o_miso_oe_n,
  output logic [23:0] o_config,
  output logic o_config_valid
);
  tscn_state_type state;
  tscn_state_type next_state;
  logic [TIMER_W-1:0] timer;
  logic ss_n_sync;
  logic done_sync;
  logic done_seen;
  logic frame_done;
  logic link_clr;
  logic [23:0] tx_word;
  logic [23:0] rx_word;
  logic link_miso;
  logic [1:0] byte_cnt;
  logic float_req;
  logic done_tgl_w;
  logic sleep_sync;

  function automatic logic timer_hit(input logic [TIMER_W-1:0] t, input int unsigned lim);
    timer_hit = (t >= TIMER_W'(lim));
  endfunction

  tscn_sync u_ss_sync
  (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_async(i_ss_n),
    .o_sync(ss_n_sync)
  );

  tscn_sync u_done_sync
  (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_async(done_tgl_w),
    .o_sync(done_sync)
  );

  // Sleep is a pin with no relation to the core clock
  tscn_sync u_sleep_sync
  (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_async(i_sleep),
    .o_sync(sleep_sync)
  );

  // Only the host clocks the link; the device never makes a link clock
  tscn_link_shift u_link
  (
    .i_link_clk(i_link_clk),
    .i_link_clr(link_clr),
    .i_tx_word(tx_word),
    .i_mosi(i_mosi),
    .o_miso(link_miso),
    .o_rx_word(rx_word),
    .o_done_tgl(done_tgl_w),
    .o_byte_cnt(byte_cnt)
  );

  // Frame end arrives as a level flag from the link domain; only its rise counts
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      done_seen <= 1'b0;
    end
    else
    begin
      done_seen <= done_sync;
    end
  end

  assign frame_done = done_sync && !done_seen;

  // Link logic held clear except while a frame may run; a frame continues through select gaps
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      link_clr <= 1'b1;
    end
    else
    begin
      link_clr <= (next_state == TSCN_BUSY);
    end
  end

  always_comb
  begin
    next_state = state;
    unique case (state)
      TSCN_BUSY:
      begin
        // Ready rises only with select idle high
        if (timer_hit(timer, BURST) && ss_n_sync && !sleep_sync)
        begin
          next_state = TSCN_READY;
        end
      end
      TSCN_READY:
      begin
        if (!ss_n_sync)
        begin
          next_state = TSCN_SHIFT;
        end
      end
      TSCN_SHIFT:
      begin
        if (frame_done || timer_hit(timer, XFER_TIMEOUT))
        begin
          next_state = TSCN_BUSY;
        end
      end
      default:
      begin
        next_state = TSCN_BUSY;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      state <= TSCN_BUSY;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst || next_state != state)
    begin
      timer <= '0;
    end
    else if (timer != '1)
    begin
      timer <= timer + 1'b1;
    end
  end

  // Ready high in READY and SHIFT; falls after third byte or on timeout
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_transfer_ready_handshake <= 1'b0;
    end
    else
    begin
      o_transfer_ready_handshake <= (next_state != TSCN_BUSY);
    end
  end

  // Status snapshot is frozen while a frame shifts
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      tx_word <= STATUS_RESET;
    end
    else if (state != TSCN_SHIFT)
    begin
      tx_word <= i_key_status;
    end
  end

  // Configuration takes effect only after all three bytes arrive
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_config <= CFG_RESET;
      o_config_valid <= 1'b0;
    end
    else
    begin
      o_config_valid <= (state == TSCN_SHIFT) && frame_done;
      if ((state == TSCN_SHIFT) && frame_done)
      begin
        o_config <= rx_word;
      end
    end
  end

  // Reset sets change; event set wins over the third-byte clear
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_change <= 1'b1;
    end
    else if (i_state_event)
    begin
      o_change <= 1'b1;
    end
    else if ((state == TSCN_SHIFT) && frame_done)
    begin
      o_change <= 1'b0;
    end
  end

  // Float floatable outputs during reset, and during sleep while the state is busy; enables are active low
  assign float_req = i_rst || (sleep_sync && state == TSCN_BUSY);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_change_oe_n <= 1'b1;
      o_transfer_ready_handshake_oe_n <= 1'b1;
    end
    else
    begin
      o_change_oe_n <= float_req;
      o_transfer_ready_handshake_oe_n <= float_req;
    end
  end

  // Data-out is driven only while selected in a frame; bit picked from the core-domain status snapshot by the link-domain index
  assign o_miso = link_miso;
  assign o_miso_oe_n = ss_n_sync || (state != TSCN_SHIFT);

  sequence seq_frame_end;
    (state == TSCN_SHIFT) && frame_done;
  endsequence

  AST_CHANGE_AFTER_RESET: assert property (@(posedge i_ref_clk)
    $fell(i_rst) |-> o_change)
    else $error("change not high after reset");

  AST_CHANGE_ON_EVENT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_state_event |=> o_change)
    else $error("change not raised by event");

  AST_CHANGE_CLEAR: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    seq_frame_end ##0 !i_state_event |=> !o_change)
    else $error("change not cleared at frame end");

  AST_CHANGE_HOLDS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_change && !(state == TSCN_SHIFT && frame_done) |=> o_change)
    else $error("change dropped without a read");

  AST_READY_FALLS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    seq_frame_end |=> !o_transfer_ready_handshake)
    else $error("ready not dropped after third byte");

  AST_READY_NEEDS_IDLE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_transfer_ready_handshake) |-> $past(ss_n_sync))
    else $error("ready raised while selected");

  AST_CONFIG_LOAD: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    seq_frame_end |=> o_config_valid && o_config == $past(rx_word))
    else $error("config not loaded at frame end");

  AST_FLOAT_SLEEP: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    sleep_sync && state == TSCN_BUSY |=> o_change_oe_n && o_transfer_ready_handshake_oe_n)
    else $error("outputs driven in sleep");

  AST_TIMEOUT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    state == TSCN_SHIFT && timer_hit(timer, XFER_TIMEOUT) |=> state == TSCN_BUSY)
    else $error("frame timeout ignored");

  AST_FLOAT_RESET: assert property (@(posedge i_ref_clk)
    i_rst |=> o_change_oe_n && o_transfer_ready_handshake_oe_n && o_change)
    else $error("outputs driven or change low in reset");

  AST_READY_LOW_STANDS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $fell(o_transfer_ready_handshake) |=> !o_transfer_ready_handshake)
    else $error("ready rose right after falling");
endmodule

// ---- logic/tscn_pkg.sv ----
// Purpose: Shared constants for the touch state-change notify block.
// Assumes: Reference clock at 20 MHz; serial link mode 3 (idle high).
// Notes: Timing counts derive from printed times and the clock period.
package tscn_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned XFER_BYTES = 3;
  localparam logic [4:0] XFER_BITS = 5'h18;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam logic [1:0] BYTE_CNT_LAST = 2'h2;
  // Ready-high least time and transfer timeout
  localparam int unsigned READY_MIN_US = 450;
  localparam int unsigned XFER_TIMEOUT_MS = 10;
  localparam int unsigned READY_MIN_CYC = (READY_MIN_US * 1000 + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int unsigned XFER_TIMEOUT_CYC = (XFER_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
  // Busy time after a transfer, standing in for a sense burst
  localparam int unsigned BURST_US = 100;
  localparam int unsigned BURST_CYC = (BURST_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W = 18;
  localparam logic [23:0] CFG_RESET = 24'h000000;
  localparam logic [23:0] STATUS_RESET = 24'h000000;

  typedef enum logic [1:0]
  {
    TSCN_BUSY = 2'b00,
    TSCN_READY = 2'b01,
    TSCN_SHIFT = 2'b10
  } tscn_state_type;
endpackage

// ---- logic/tscn_link_shift.sv ----
// Purpose: Link-clock side of the serial slave: shifts three bytes each way.
// Assumes: Clock idles high, input sampled on rising, output changes on falling.
// Notes: Frame end is a level flag held until the core clears the link logic.
`timescale 1ns/100ps
module tscn_link_shift
  import tscn_pkg::*;
(
  input wire logic i_link_clk,
  input wire logic i_link_clr,
  input wire logic [23:0] i_tx_word,
  input wire logic i_mosi,
  output logic o_miso,
  output logic [23:0] o_rx_word,
  output logic o_done_tgl,
  output logic [1:0] o_byte_cnt
);
  logic [2:0] bit_cnt;
  logic [23:0] rx_shift;
  logic [4:0] out_idx;
  logic lead_seen;

  // Clear comes from the core domain; link clock may stand still, so it is asynchronous
  always_ff @(posedge i_link_clk or posedge i_link_clr)
  begin
    if (i_link_clr)
    begin
      bit_cnt <= 3'h0;
      o_byte_cnt <= 2'h0;
      rx_shift <= 24'h000000;
      o_done_tgl <= 1'b0;
    end
    else
    begin
      rx_shift <= {rx_shift[22:0], i_mosi};
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == BIT_CNT_LAST)
      begin
        o_byte_cnt <= (o_byte_cnt == BYTE_CNT_LAST) ? 2'h0 : o_byte_cnt + 2'h1;
      end
      // Done stays set until the core clears the link, so it acts only on a rise
      if (bit_cnt == BIT_CNT_LAST && o_byte_cnt == BYTE_CNT_LAST)
      begin
        o_done_tgl <= 1'b1;
      end
    end
  end

  // Word keeps the last frame; the core copies it only after done is seen
  always_ff @(posedge i_link_clk)
  begin
    if (!i_link_clr && bit_cnt == BIT_CNT_LAST && o_byte_cnt == BYTE_CNT_LAST)
    begin
      o_rx_word <= {rx_shift[22:0], i_mosi};
    end
  end

  // First falling edge keeps the first bit on the line; later ones advance
  always_ff @(negedge i_link_clk or posedge i_link_clr)
  begin
    if (i_link_clr)
    begin
      out_idx <= 5'h00;
      lead_seen <= 1'b0;
    end
    else if (!lead_seen)
    begin
      lead_seen <= 1'b1;
    end
    else if (out_idx != XFER_BITS - 5'h01)
    begin
      out_idx <= out_idx + 5'h01;
    end
  end

  assign o_miso = i_tx_word[5'h17 - out_idx];
endmodule

// ---- logic/tscn_sync.sv ----
// Purpose: Two-flop level synchroniser into the reference clock.
// Assumes: Input is a slow level or a toggle from another domain.
// Notes: First stage feeds only the second.
`timescale 1ns/100ps
module tscn_sync
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_sync
);
  logic meta;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      meta <= 1'b0;
      o_sync <= 1'b0;
    end
    else
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// ---- bench/tscn_host_model.sv ----
// Purpose: Host master model driving select, link clock and data-in.
// Assumes: Clock idles high; data out on falling, sampled on rising.
// Notes: Link clock stands still between frames.
`timescale 1ns/100ps
module tscn_host_model
(
  input wire logic i_miso,
  input wire logic i_miso_oe_n,
  output logic o_ss_n,
  output logic o_link_clk,
  output logic o_mosi
);
  logic last_miso = 1'b0;
  initial
  begin
    o_ss_n = 1'b1;
    o_link_clk = 1'b1;
    o_mosi = 1'b1;
  end
  // Select alone, with no clocks, for stalled frames
  task automatic hold_select(input logic lvl);
    o_ss_n = lvl;
  endtask
  // Undriven line reads as the inverse of the last bit, not a stale copy
  task automatic transfer(input logic [23:0] tx, output logic [23:0] rx);
    o_ss_n = 1'b0;
    #23000;
    for (int i = 23; i >= 0; i--)
    begin
      o_link_clk = 1'b0;
      o_mosi = tx[i];
      #40;
      o_link_clk = 1'b1;
      rx[i] = i_miso_oe_n ? ~last_miso : i_miso;
      last_miso = rx[i];
      #40;
    end
    #1000;
    o_ss_n = 1'b1;
  endtask
endmodule

// ---- bench/test_touch_state_change_notify.sv ----
// Purpose: Self-checking bench for the state-change notify block.
// Assumes: Host model owns the link; short counts set by parameter.
// Notes: Frames wait for ready before select drops.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module test_touch_state_change_notify
  import tscn_pkg::*;
;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_sleep = 1'b0;
  logic i_state_event = 1'b0;
  logic [23:0] i_key_status = 24'h000000;
  logic ss_n, link_clk, mosi, miso, miso_oe_n, change, change_oe_n, rdy, rdy_oe_n, cfg_v;
  logic [23:0] cfg;
  int n_errors = 0;
  int n_checks = 0;
  always #25 i_ref_clk = ~i_ref_clk;
  tscn_notify #(.READY_MIN(64), .XFER_TIMEOUT(4000), .BURST(50)) i_dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_link_clk(link_clk), .i_ss_n(ss_n),
    .i_mosi(mosi), .i_sleep(i_sleep), .i_key_status(i_key_status),
    .i_state_event(i_state_event), .o_change(change), .o_change_oe_n(change_oe_n),
    .o_transfer_ready_handshake(rdy), .o_transfer_ready_handshake_oe_n(rdy_oe_n),
    .o_miso(miso), .o_miso_oe_n(miso_oe_n), .o_config(cfg), .o_config_valid(cfg_v));
  tscn_host_model i_host (.i_miso(miso), .i_miso_oe_n(miso_oe_n), .o_ss_n(ss_n),
    .o_link_clk(link_clk), .o_mosi(mosi));
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wait_ready();
    int k;
    k = 0;
    while (rdy !== 1'b1 && k < 2000)
    begin
      tick(1);
      k++;
    end
    `CHK("ready wait", 1'b1, rdy)
    if (rdy !== 1'b1)
      complete_run();
  endtask
  task automatic do_reset();
    @(posedge i_ref_clk) i_rst <= 1'b1;
    tick(3);
    `CHK("change in reset", 1'b1, change)
    `CHK("change oe in reset", 1'b1, change_oe_n)
    `CHK("ready oe in reset", 1'b1, rdy_oe_n)
    @(posedge i_ref_clk) i_rst <= 1'b0;
    tick(2);
    `CHK("change after reset", 1'b1, change)
    wait_ready();
  endtask
  task automatic do_frame(input logic [23:0] tx, input logic [23:0] keys);
    logic [23:0] rx;
    int k;
    k = 0;
    @(posedge i_ref_clk) i_key_status <= keys;
    tick(1);
    fork
      i_host.transfer(tx, rx);
      begin
        while (cfg_v !== 1'b1 && k < 2000)
        begin
          tick(1);
          k++;
        end
        `CHK("config valid", 1'b1, cfg_v)
        `CHK("config", tx, cfg)
        `CHK("change cleared", 1'b0, change)
        `CHK("ready fell", 1'b0, rdy)
      end
    join
    `CHK("key word", keys, rx)
    if (k >= 2000)
      complete_run();
  endtask
  task automatic event_raises();
    tick(2);
    `CHK("change idle", 1'b0, change)
    @(posedge i_ref_clk) i_state_event <= 1'b1;
    @(posedge i_ref_clk) i_state_event <= 1'b0;
    tick(3);
    `CHK("change on event", 1'b1, change)
  endtask
  task automatic sleep_floats();
    @(posedge i_ref_clk) i_sleep <= 1'b1;
    tick(3);
    `CHK("change oe asleep", 1'b1, change_oe_n)
    `CHK("ready oe asleep", 1'b1, rdy_oe_n)
    `CHK("miso oe asleep", 1'b1, miso_oe_n)
    @(posedge i_ref_clk) i_sleep <= 1'b0;
    tick(3);
    `CHK("change oe awake", 1'b0, change_oe_n)
    `CHK("ready oe awake", 1'b0, rdy_oe_n)
  endtask
  // Select held low with no clocks: the frame times out and nothing is taken
  task automatic timeout_frame();
    int k;
    k = 0;
    i_host.hold_select(1'b0);
    while (rdy !== 1'b0 && k < 5000)
    begin
      tick(1);
      k++;
    end
    `CHK("ready timeout", 1'b0, rdy)
    tick(100);
    `CHK("ready held by select", 1'b0, rdy)
    `CHK("change kept", 1'b1, change)
    `CHK("config kept", 24'hA5C33C, cfg)
    i_host.hold_select(1'b1);
    if (k >= 5000)
      complete_run();
  endtask
  initial
  begin
    do_reset();
    do_frame(24'hA5C33C, 24'h8100FF);
    event_raises();
    sleep_floats();
    wait_ready();
    timeout_frame();
    wait_ready();
    do_frame(24'h5A0F01, 24'h7E8001);
    do_reset();
    do_frame(24'hFFFFFF, 24'h000000);
    complete_run();
  end
endmodule
